//--- include/dtpwm_pkg.sv
`default_nettype none

package dtpwm_pkg;

  // Register indices; byte address is four times the index.
  localparam logic [2:0] IDX_COUNT    = 3'h0;
  localparam logic [2:0] IDX_CTRL_A   = 3'h1;
  localparam logic [2:0] IDX_CTRL_B   = 3'h2;
  localparam logic [2:0] IDX_DUTY     = 3'h3;
  localparam logic [2:0] IDX_PRESCALE = 3'h4;
  localparam logic [2:0] IDX_IRQ      = 3'h5;

  // Field positions in timer_control_a.
  localparam int CA_RUN    = 0;
  localparam int CA_RELOAD = 1;
  localparam int CA_ONESHOT = 2;
  localparam int CA_PWM_AL = 6;
  localparam int CA_PWM_OE = 7;

  // Field positions in timer_control_b.
  localparam int CB_RATE_LSB = 0;
  localparam int CB_PS_EN_N  = 3;
  localparam int CB_EDGE     = 4;
  localparam int CB_SRC      = 5;

  // Field positions in the interrupt register of this block.
  localparam int IRQ_FLAG = 0;
  localparam int IRQ_EN   = 1;

  // Reset values, then the wrap and zero values of the counter.
  localparam logic [7:0] CTRL_A_RST    = 8'h00;
  localparam logic [5:0] CTRL_B_RST    = 6'h3f;
  localparam logic [7:0] PRESCALE_RST  = 8'hff;
  localparam logic [7:0] COUNT_RST     = 8'hff;
  localparam logic [7:0] COUNT_WRAP    = 8'hff;
  localparam logic [7:0] COUNT_ZERO    = 8'h00;

  // Instruction clock ticks when the divider reaches this count, so it is the system clock divided by two.
  localparam logic [1:0] INSTR_DIV_LAST = 2'h1;

endpackage : dtpwm_pkg

`default_nettype wire

//--- hdl/dtpwm_timer.sv
`timescale 1ns/1ps
`default_nettype none

module dtpwm_timer (
  input  wire logic       clk_sys,             // System clock, 200 MHz.
  input  wire logic       sys_rst,             // Synchronous reset, active high.
  input  wire logic [4:0] avs_address,         // Byte address.
  input  wire logic       avs_read,            // Read request.
  input  wire logic       avs_write,           // Write request.
  input  wire logic [31:0] avs_writedata,      // Write data.
  input  wire logic [3:0] avs_byteenable,      // Byte enables.
  output logic [31:0]     avs_readdata,        // Read data.
  output logic            avs_waitrequest,     // Stall while high.
  input  wire logic       external_clock_pin,  // Asynchronous external count clock.
  input  wire logic       pin_select,          // Picks pin two when high, pin six when low.
  output logic            port_b_pin_six,      // PWM level on pin six.
  output logic            port_b_pin_six_oe,   // High while PWM drives pin six.
  output logic            port_b_pin_two,      // PWM level on pin two.
  output logic            port_b_pin_two_oe,   // High while PWM drives pin two.
  output logic            underflow_irq        // Flag gated by its enable.
);

  ////////////////////////////////////////////////////////////////////////////////
  // Register state.

  logic [7:0] count;          // Live down counter.
  logic [7:0] reload;         // Stored reload value.
  logic [7:0] ctrl_a;         // Control register A.
  logic [5:0] ctrl_b;         // Control register B.
  logic [7:0] duty;           // Write-only duty value.
  logic [7:0] prescale;       // Prescaler counter, counts down.
  logic       irq_flag;       // Sticky underflow flag.
  logic       irq_en;         // Underflow interrupt enable.
  logic       stopped;        // One-shot has finished.
  logic       pwm_active;     // PWM is in its active phase.
  logic       ack;            // Answer cycle of the bus.
  logic       sel_meta;       // First synchroniser stage of the pin choice.
  logic       sel_latched;    // Pin choice after its second synchroniser stage.

  // Decoded access strobes.
  logic       acc;
  logic       wr_hit;
  logic       rd_hit;
  logic [2:0] idx;

  assign acc    = (avs_read | avs_write) & ~ack;
  assign idx    = avs_address[4:2];
  assign wr_hit = avs_write & ack & avs_byteenable[0];
  assign rd_hit = avs_read & ~ack;

  ////////////////////////////////////////////////////////////////////////////////
  // Bus handshake: every access waits one cycle, then completes.

  // Waitrequest is a flop; it drops for one cycle after each new request.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= ~acc;
    end
  end

  // The answer cycle is the one in which waitrequest stands low.
  assign ack = ~avs_waitrequest;

  // Read data is registered on the request cycle and stands in the answer cycle.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      avs_readdata <= 32'h0000_0000;
    end else if (rd_hit) begin
      unique case (idx)
        dtpwm_pkg::IDX_COUNT:    avs_readdata <= {24'h000000, count};
        dtpwm_pkg::IDX_CTRL_A:   avs_readdata <= {29'h00000000, ctrl_a[2:0]};
        dtpwm_pkg::IDX_CTRL_B:   avs_readdata <= {26'h0000000, ctrl_b};
        dtpwm_pkg::IDX_PRESCALE: avs_readdata <= {24'h000000, prescale};
        dtpwm_pkg::IDX_IRQ:      avs_readdata <= {30'h00000000, irq_en, irq_flag & irq_en};
        default:                 avs_readdata <= 32'h0000_0000;
      endcase
    end
  end

  // A write takes effect only at the edge where the master sees waitrequest low.
  logic wr_count;
  logic wr_ctrl_a;
  logic wr_irq;
  assign wr_count  = wr_hit && idx == dtpwm_pkg::IDX_COUNT;
  assign wr_ctrl_a = wr_hit && idx == dtpwm_pkg::IDX_CTRL_A;
  assign wr_irq    = wr_hit && idx == dtpwm_pkg::IDX_IRQ;

  ////////////////////////////////////////////////////////////////////////////////
  // Control registers.

  // Control A resets with run, reload and one-shot all zero.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      ctrl_a <= dtpwm_pkg::CTRL_A_RST;
    end else if (wr_ctrl_a) begin
      ctrl_a <= avs_writedata[7:0];
    end
  end

  // Control B holds rate, prescaler disable, edge and source.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      ctrl_b <= dtpwm_pkg::CTRL_B_RST;
    end else if (wr_hit && idx == dtpwm_pkg::IDX_CTRL_B) begin
      ctrl_b <= avs_writedata[5:0];
    end
  end

  // Duty value sets the compare point.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      duty <= 8'h00;
    end else if (wr_hit && idx == dtpwm_pkg::IDX_DUTY) begin
      duty <= avs_writedata[7:0];
    end
  end

  // Reload register follows every count write.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      reload <= dtpwm_pkg::COUNT_RST;
    end else if (wr_count) begin
      reload <= avs_writedata[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Count source: instruction clock or synchronised external pin.

  logic [1:0] instr_div;  // Instruction clock divider.
  logic       instr_tick; // One instruction cycle.
  logic       ext_meta;   // First synchroniser stage.
  logic       ext_sync;   // Second synchroniser stage.
  logic       ext_prev;   // Delayed copy for edge detection.

  // The instruction clock runs at half the system rate.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      instr_div <= 2'h0;
    end else if (instr_div == dtpwm_pkg::INSTR_DIV_LAST) begin
      instr_div <= 2'h0;
    end else begin
      instr_div <= instr_div + 2'h1;
    end
  end
  assign instr_tick = (instr_div == dtpwm_pkg::INSTR_DIV_LAST);

  // Two flops before the edge detector sees the pin.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      ext_meta <= 1'b0;
      ext_sync <= 1'b0;
      ext_prev <= 1'b0;
    end else begin
      ext_meta <= external_clock_pin;
      ext_sync <= ext_meta;
      ext_prev <= ext_sync;
    end
  end

  logic ext_edge;
  logic src_event;
  // Falling edge when edge select is one, rising otherwise.
  assign ext_edge  = ctrl_b[dtpwm_pkg::CB_EDGE] ? (ext_prev & ~ext_sync)
                                                : (~ext_prev & ext_sync);
  assign src_event = ctrl_b[dtpwm_pkg::CB_SRC] ? ext_edge : instr_tick;

  ////////////////////////////////////////////////////////////////////////////////
  // Prescaler: down counter, tick when the selected bit rises from 0 to 1.

  logic       ps_on;
  logic [7:0] next_prescale;
  logic       ps_tick;
  logic       run;
  logic       dec;

  assign ps_on         = ~ctrl_b[dtpwm_pkg::CB_PS_EN_N];
  assign run           = ctrl_a[dtpwm_pkg::CA_RUN] & ~stopped;
  assign next_prescale = prescale - 8'h01;
  // Bit n wraps from 0 to 1 once every 2^(n+1) decrements.
  assign ps_tick       = ~prescale[ctrl_b[2:0]] & next_prescale[ctrl_b[2:0]];
  assign dec           = run & src_event & (ps_on ? ps_tick : 1'b1);

  // The prescaler advances on every source event while enabled and running.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      prescale <= dtpwm_pkg::PRESCALE_RST;
    end else if (ps_on && run && src_event) begin
      prescale <= next_prescale;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Down counter with wrap, reload and one-shot modes.

  logic underflow;
  assign underflow = dec && count == dtpwm_pkg::COUNT_ZERO;

  // Count write wins; otherwise decrement, and on underflow pick the next value.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      count <= dtpwm_pkg::COUNT_RST;
    end else if (wr_count) begin
      count <= avs_writedata[7:0];
    end else if (underflow) begin
      if (ctrl_a[dtpwm_pkg::CA_ONESHOT]) begin
        count <= count;
      end else if (ctrl_a[dtpwm_pkg::CA_RELOAD]) begin
        count <= reload;
      end else begin
        count <= dtpwm_pkg::COUNT_WRAP;
      end
    end else if (dec) begin
      count <= count - 8'h01;
    end
  end

  // One-shot halts after its underflow; a count or control A write restarts it.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      stopped <= 1'b0;
    end else if (wr_count || wr_ctrl_a) begin
      stopped <= 1'b0;
    end else if (underflow && ctrl_a[dtpwm_pkg::CA_ONESHOT]) begin
      stopped <= 1'b1;
    end
  end

  // Sticky flag; a new underflow wins over a clear in the same cycle.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      irq_flag <= 1'b0;
      irq_en   <= 1'b0;
    end else begin
      if (underflow) begin
        irq_flag <= 1'b1;
      end else if (wr_irq && !avs_writedata[dtpwm_pkg::IRQ_FLAG]) begin
        irq_flag <= 1'b0;
      end
      if (wr_irq) begin
        irq_en <= avs_writedata[dtpwm_pkg::IRQ_EN];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // PWM: inactive until compare, active until underflow.

  // Compare match turns the output on; underflow or stop turns it off.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      pwm_active <= 1'b0;
    end else if (!ctrl_a[dtpwm_pkg::CA_RUN] || underflow) begin
      pwm_active <= 1'b0;
    end else if (run && count == duty) begin
      pwm_active <= 1'b1;
    end
  end

  // Pin choice comes from outside, so it passes two flops before the routing reads it.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      sel_meta    <= 1'b0;
      sel_latched <= 1'b0;
    end else begin
      sel_meta    <= pin_select;
      sel_latched <= sel_meta;
    end
  end

  // Output flops with polarity and routing applied.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      port_b_pin_six    <= 1'b0;
      port_b_pin_two    <= 1'b0;
      port_b_pin_six_oe <= 1'b0;
      port_b_pin_two_oe <= 1'b0;
      underflow_irq     <= 1'b0;
    end else begin
      port_b_pin_six    <= pwm_active ^ ctrl_a[dtpwm_pkg::CA_PWM_AL];
      port_b_pin_two    <= pwm_active ^ ctrl_a[dtpwm_pkg::CA_PWM_AL];
      port_b_pin_six_oe <= ctrl_a[dtpwm_pkg::CA_PWM_OE] & ~sel_latched;
      port_b_pin_two_oe <= ctrl_a[dtpwm_pkg::CA_PWM_OE] & sel_latched;
      underflow_irq     <= irq_flag & irq_en;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.

  chk_count_write: assert property (@(posedge clk_sys) disable iff (sys_rst)
    wr_count |=> (count == $past(avs_writedata[7:0]) && reload == $past(avs_writedata[7:0])))
    else $error("count write did not load counter and reload");
  chk_run_gate: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (!ctrl_a[dtpwm_pkg::CA_RUN] && !wr_count) |=> $stable(count))
    else $error("counter moved while disabled");
  chk_wrap_ff: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (underflow && !wr_count && ctrl_a[2:1] == 2'b00) |=> count == 8'hff)
    else $error("free-run wrap not 0xff");
  chk_reload_val: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (underflow && !wr_count && ctrl_a[2:1] == 2'b01) |=> count == $past(reload))
    else $error("reload mode did not reload");
  chk_oneshot_stop: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (underflow && !wr_count && ctrl_a[dtpwm_pkg::CA_ONESHOT]) |=> (count == 8'h00 && stopped))
    else $error("one-shot did not stop at zero");
  chk_ext_sync: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (ctrl_b[dtpwm_pkg::CB_SRC] && src_event) |->
      ($past(external_clock_pin, 2) != $past(external_clock_pin, 3) &&
       $past(external_clock_pin, 2) == !ctrl_b[dtpwm_pkg::CB_EDGE]))
    else $error("external event without synchronised edge");
  chk_pwm_match: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (run && count == duty && !underflow && ctrl_a[dtpwm_pkg::CA_RUN]) |=> pwm_active)
    else $error("pwm not active after compare");
  chk_pwm_off: assert property (@(posedge clk_sys) disable iff (sys_rst)
    underflow |=> !pwm_active ##1 (port_b_pin_six == ctrl_a[dtpwm_pkg::CA_PWM_AL]))
    else $error("pwm not inactive after underflow");
  chk_flag_sticky: assert property (@(posedge clk_sys) disable iff (sys_rst)
    underflow |=> irq_flag)
    else $error("underflow did not set flag");
  chk_irq_mask: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !irq_en |=> !underflow_irq)
    else $error("masked flag reached output");

  cov_underflow: cover property (@(posedge clk_sys) disable iff (sys_rst) underflow);
  cov_prescaled: cover property (@(posedge clk_sys) disable iff (sys_rst) dec && ps_on);
  cov_oneshot:   cover property (@(posedge clk_sys) disable iff (sys_rst) $rose(stopped));
  cov_pwm:       cover property (@(posedge clk_sys) disable iff (sys_rst) $rose(pwm_active));

endmodule : dtpwm_timer

`default_nettype wire

//--- verif/downcount_timer_with_pwm_test.sv
`timescale 1ns/1ps
`default_nettype none

// Counts one comparison and reports a mismatch at once.
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin miscompares++; \
  $display("FAIL %s expected %h seen %h", nm, e, g); end end

module downcount_timer_with_pwm_test;
  logic        clk_sys = 1'b0;             // System clock, 200 MHz.
  logic        sys_rst = 1'b1;             // Synchronous reset, held at start.
  logic [4:0]  avs_address = 5'h00;        // Byte address.
  logic        avs_read = 1'b0;            // Read request.
  logic        avs_write = 1'b0;           // Write request.
  logic [31:0] avs_writedata = 32'h0;      // Write data.
  logic [3:0]  avs_byteenable = 4'hf;      // Byte enables.
  logic [31:0] avs_readdata;               // Read data.
  logic        avs_waitrequest;            // Stall from the block.
  logic        external_clock_pin = 1'b0;  // Count clock made by the bench.
  logic        pin_select = 1'b0;          // Picks which port pin carries PWM.
  logic        port_b_pin_six, port_b_pin_six_oe, port_b_pin_two, port_b_pin_two_oe;
  logic        underflow_irq;              // Gated flag output.
  int          miscompares = 0;            // Mismatches seen.
  int          check_count = 0;            // Comparisons made.
  logic [31:0] exp_q[$];                   // Expected read data, oldest first.
  logic [31:0] msk_q[$];                   // Bits of each read that matter.
  logic [31:0] last_rd;                    // Most recent read data.
  logic [7:0]  v;                          // Random count value.
  logic        sel;                        // Random pin choice.

  dtpwm_timer i_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .external_clock_pin(external_clock_pin), .pin_select(pin_select),
    .port_b_pin_six(port_b_pin_six), .port_b_pin_six_oe(port_b_pin_six_oe),
    .port_b_pin_two(port_b_pin_two), .port_b_pin_two_oe(port_b_pin_two_oe),
    .underflow_irq(underflow_irq));

  // Free-running clock, 5 ns period.
  always #2.5 clk_sys = ~clk_sys;

  ////////////////////////////////////////////////////////////////////////////
  // Prints the counts and the verdict, then ends the run.
  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : report_and_stop

  // One bus access; the request is held until waitrequest is sampled low at a rising edge.
  task automatic access(input logic is_wr, input logic [2:0] idx, input logic [7:0] d);
    int n;
    n = 0;
    avs_address   <= {idx, 2'b00};
    avs_writedata <= {24'h0, d};
    avs_write     <= is_wr;
    avs_read      <= !is_wr;
    @(posedge clk_sys);
    while (avs_waitrequest !== 1'b0) begin
      n++;
      // A slave that never answers ends the run as a failure.
      if (n > 20) begin
        miscompares++;
        $display("FAIL waitrequest expected 0 seen %b", avs_waitrequest);
        report_and_stop();
      end
      @(posedge clk_sys);
    end
    // Released just after the answer edge; one idle edge keeps the next request apart.
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    @(posedge clk_sys);
  endtask : access

  // Register write of one byte.
  task automatic wr(input logic [2:0] idx, input logic [7:0] d);
    access(1'b1, idx, d);
  endtask : wr

  // Register read; the expectation is noted before the request goes out.
  task automatic rd(input logic [2:0] idx, input logic [31:0] e, input logic [31:0] m = 32'hffffffff);
    exp_q.push_back(e);
    msk_q.push_back(m);
    access(1'b0, idx, 8'h00);
  endtask : rd

  // Full pulses on the count pin, long enough for the synchroniser.
  task automatic pulse(input int n);
    repeat (n) begin
      external_clock_pin <= 1'b1;
      repeat (5) @(posedge clk_sys);
      external_clock_pin <= 1'b0;
      repeat (5) @(posedge clk_sys);
    end
  endtask : pulse

  // Checks the PWM pins on a settled half cycle.
  task automatic chk_pwm(input logic lvl, input logic s);
    @(negedge clk_sys);
    `CHK("pwm_pin", lvl, (s ? port_b_pin_two : port_b_pin_six))
    `CHK("pwm_oe", {s, !s}, {port_b_pin_two_oe, port_b_pin_six_oe})
    @(posedge clk_sys);
  endtask : chk_pwm

  ////////////////////////////////////////////////////////////////////////////
  // Watches answers and compares each with the oldest note.
  // Read data is taken at the rising edge where waitrequest is sampled low.
  always @(posedge clk_sys) begin
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
      last_rd = avs_readdata;
      if (exp_q.size() == 0) begin
        `CHK("unexpected_read", 1'b0, 1'b1)
      end else begin
        `CHK("readdata", exp_q.pop_front(), avs_readdata & msk_q.pop_front())
      end
    end
  end

  // Main sequence.
  initial begin
    void'($urandom(17500));
    repeat (8) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
    // Reset values, write-only and unmapped places.
    rd(dtpwm_pkg::IDX_COUNT, {24'h0, dtpwm_pkg::COUNT_RST});
    rd(dtpwm_pkg::IDX_CTRL_A, 32'h0);
    rd(dtpwm_pkg::IDX_CTRL_B, {26'h0, dtpwm_pkg::CTRL_B_RST});
    rd(dtpwm_pkg::IDX_PRESCALE, 32'hff);
    rd(dtpwm_pkg::IDX_DUTY, 32'h0);
    rd(dtpwm_pkg::IDX_IRQ, 32'h0);
    rd(3'h6, 32'h0);
    // Count writes land in the live counter; a write without byte 0 is ignored.
    for (int i = 0; i < 4; i++) begin
      v = 8'($urandom);
      wr(dtpwm_pkg::IDX_COUNT, v);
      rd(dtpwm_pkg::IDX_COUNT, {24'h0, v});
    end
    avs_byteenable <= 4'h0;
    wr(dtpwm_pkg::IDX_COUNT, ~v);
    avs_byteenable <= 4'hf;
    rd(dtpwm_pkg::IDX_COUNT, {24'h0, v});
    // Pin source, rising edge, no prescaler: wrap to 0xff and flag.
    wr(dtpwm_pkg::IDX_CTRL_B, 8'h28);
    wr(dtpwm_pkg::IDX_IRQ, 8'h02);
    wr(dtpwm_pkg::IDX_COUNT, 8'h02);
    wr(dtpwm_pkg::IDX_CTRL_A, 8'h01);
    pulse(3);
    rd(dtpwm_pkg::IDX_COUNT, 32'hff);
    rd(dtpwm_pkg::IDX_IRQ, 32'h3);
    `CHK("underflow_irq", 1'b1, underflow_irq)
    wr(dtpwm_pkg::IDX_IRQ, 8'h02);
    rd(dtpwm_pkg::IDX_IRQ, 32'h2);
    pulse(1);
    rd(dtpwm_pkg::IDX_COUNT, 32'hfe);
    // Reload on underflow.
    wr(dtpwm_pkg::IDX_COUNT, 8'h05);
    wr(dtpwm_pkg::IDX_CTRL_A, 8'h03);
    pulse(6);
    rd(dtpwm_pkg::IDX_COUNT, 32'h5);
    // One-shot with both reload settings, flag enable off.
    wr(dtpwm_pkg::IDX_IRQ, 8'h00);
    for (int j = 0; j < 2; j++) begin
      wr(dtpwm_pkg::IDX_COUNT, 8'h03);
      wr(dtpwm_pkg::IDX_CTRL_A, j ? 8'h07 : 8'h05);
      pulse(4);
      rd(dtpwm_pkg::IDX_COUNT, 32'h0);
      pulse(3);
      rd(dtpwm_pkg::IDX_COUNT, 32'h0);
    end
    rd(dtpwm_pkg::IDX_IRQ, 32'h0);
    `CHK("underflow_irq", 1'b0, underflow_irq)
    wr(dtpwm_pkg::IDX_IRQ, 8'h03);
    rd(dtpwm_pkg::IDX_IRQ, 32'h3);
    // Falling edge selected: only the falling edge counts.
    wr(dtpwm_pkg::IDX_CTRL_B, 8'h38);
    wr(dtpwm_pkg::IDX_COUNT, 8'h10);
    wr(dtpwm_pkg::IDX_CTRL_A, 8'h01);
    external_clock_pin <= 1'b1;
    repeat (5) @(posedge clk_sys);
    rd(dtpwm_pkg::IDX_COUNT, 32'h10);
    external_clock_pin <= 1'b0;
    repeat (5) @(posedge clk_sys);
    rd(dtpwm_pkg::IDX_COUNT, 32'h0f);
    wr(dtpwm_pkg::IDX_CTRL_A, 8'h00);
    pulse(2);
    rd(dtpwm_pkg::IDX_COUNT, 32'h0f);
    // Every rate code: one full prescaler period gives one count.
    for (int r = 0; r < 8; r++) begin
      wr(dtpwm_pkg::IDX_CTRL_B, 8'h28 | 8'(r));
      wr(dtpwm_pkg::IDX_COUNT, 8'h80);
      wr(dtpwm_pkg::IDX_CTRL_B, 8'h20 | 8'(r));
      wr(dtpwm_pkg::IDX_CTRL_A, 8'h01);
      pulse(1 << (r + 1));
      wr(dtpwm_pkg::IDX_CTRL_A, 8'h00);
      rd(dtpwm_pkg::IDX_COUNT, 32'h7f);
    end
    // Instruction clock: about one count every two cycles.
    wr(dtpwm_pkg::IDX_CTRL_B, 8'h08);
    wr(dtpwm_pkg::IDX_COUNT, 8'h80);
    wr(dtpwm_pkg::IDX_CTRL_A, 8'h01);
    repeat (20) @(posedge clk_sys);
    wr(dtpwm_pkg::IDX_CTRL_A, 8'h00);
    rd(dtpwm_pkg::IDX_COUNT, 32'h0, 32'h0);
    `CHK("instr_rate", 1'b1, ((8'h80 - last_rd[7:0]) inside {[8'd10:8'd13]}))
    // PWM in both polarities, first on a random pin and then on the other: period 5 counts, duty match at 2.
    wr(dtpwm_pkg::IDX_CTRL_B, 8'h28);
    wr(dtpwm_pkg::IDX_DUTY, 8'h02);
    for (int p = 0; p < 2; p++) begin
      sel = p ? !sel : 1'($urandom);
      pin_select <= sel;
      wr(dtpwm_pkg::IDX_COUNT, 8'h04);
      wr(dtpwm_pkg::IDX_CTRL_A, p ? 8'hc3 : 8'h83);
      repeat (3) @(posedge clk_sys);
      chk_pwm(1'(p), sel);
      for (int k = 1; k <= 5; k++) begin
        pulse(1);
        chk_pwm(1'(p) ^ (k >= 2 && k <= 4), sel);
      end
    end
    wr(dtpwm_pkg::IDX_CTRL_A, 8'h03);
    repeat (3) @(posedge clk_sys);
    `CHK("pwm_oe_off", 2'b00, {port_b_pin_two_oe, port_b_pin_six_oe})
    report_and_stop();
  end
endmodule : downcount_timer_with_pwm_test

`default_nettype wire
